// file: hw/abcc_pkg.sv
/*
 * Shared constants and types of the background calibration controller.
 * Assumes a 32-bit AHB-Lite register bus and one 50 MHz clock.
 */
package abcc_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DELAY = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_TRIM_SEL = 8'h14;
	localparam logic [7:0] ADDR_TRIM_DATA = 8'h18;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [31:0] DELAY_RST = 32'h0010_0010;
	localparam logic [15:0] TRIM_RST = 16'h0000;
	localparam int TRIM_ENTRIES = 28;
	localparam int IRQ_W = 4;
	localparam int IRQ_FOREGROUND_DONE_FLAG = 0;
	localparam int IRQ_SWAP = 1;
	localparam int IRQ_PASS = 2;
	localparam int IRQ_REFUSED = 3;
	localparam logic [4:0] IDX_OFS_END = 5'h06;
	localparam logic [4:0] IDX_BANK = 5'h06;
	localparam logic [4:0] IDX_DUAL_A = 5'h12;
	localparam logic [4:0] IDX_DUAL_B = 5'h13;
	localparam logic [4:0] IDX_DUAL_CA = 5'h14;
	localparam logic [4:0] IDX_DUAL_CB = 5'h15;
	localparam logic [4:0] IDX_A_FG90 = 5'h16;
	localparam logic [4:0] IDX_B_FG0 = 5'h17;
	localparam logic [4:0] IDX_A_BG90 = 5'h18;
	localparam logic [4:0] IDX_C_BG0 = 5'h19;
	localparam logic [4:0] IDX_C_BG90 = 5'h1A;
	localparam logic [4:0] IDX_B_BG0 = 5'h1B;
	localparam logic [1:0] CORE_A = 2'h0;
	localparam logic [1:0] CORE_B = 2'h1;
	localparam logic [1:0] CORE_C = 2'h2;
	localparam logic [1:0] CORE_ALL = 2'h3;
	localparam logic [1:0] CORE_SUM = 2'h3;
	typedef struct packed {
		logic single_ch;
		logic bg_os;
		logic fg_os;
		logic low_power_trigger_select;
		logic low_power_bg_enable;
		logic sw_trig;
		logic pin_sel;
		logic bg_en;
	} abcc_ctrl_t;
	typedef struct packed {
		logic start;
		logic offset;
		logic [1:0] core;
	} abcc_cal_req_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_FG = 3'b001,
		ST_SLEEP = 3'b010,
		ST_WAKE = 3'b011,
		ST_CAL = 3'b100,
		ST_SWAP = 3'b101
	} abcc_state_t;
endpackage

// file: hw/abcc_trim_store.sv
/*
 * Trim value store: one word per trim entry, all visible at once.
 * Assumes the caller resolves write priority and range.
 */
`timescale 1ns/10ps
module abcc_trim_store #(
	parameter int TRIM_W = 16,
	parameter int ENTRIES = 28
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [TRIM_W-1:0] wdata,
	output logic [ENTRIES*TRIM_W-1:0] trims
);
	logic [TRIM_W-1:0] mem_reg [ENTRIES];

	if (ENTRIES < 1 || ENTRIES > 32) begin : g_bad_entries
		$error("Trim store depth out of range.");
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < ENTRIES; i++) begin
			if (rst) begin
				mem_reg[i] <= abcc_pkg::TRIM_RST[TRIM_W-1:0];
			end else if (we && waddr == 5'(i)) begin
				mem_reg[i] <= wdata;
			end
		end
	end

	for (genvar g = 0; g < ENTRIES; g++) begin : g_flat
		assign trims[g*TRIM_W +: TRIM_W] = mem_reg[g];
	end
endmodule

// file: hw/abcc_ctrl.sv
/*
 * Calibration sequencer and trim control for three interleaved cores.
 * Assumes an AHB-Lite master, a calibration engine on the same clock.
 */
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
// Function
// - Background: calibrate spare, swap in, repeat.
// - Low power keeps offline spare powered down.
// - Automatic low power waits sleep delay first.
// - Woken spare settles for wake delay.
// - Low power trigger selects automatic or user swaps.
// - Foreground offset calibration runs once per foreground.
// - Background offset calibration runs every background pass.
// - Early foreground offset gives one-time correction.
// - Device writes offsets; software writes then refused.
// - One offset trim per core and input.
// - Six bank trims, minus 90 only single-channel.
// - Dual mode: trims A, B, C-for-A, C-for-B.
// - Single mode trims by core, mode, phase.
module abcc_ctrl #(
	parameter int TRIM_W = 16
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output logic IRQ,
	input wire logic CAL_TRIGGER_PIN,
	input wire logic CORE_CAL_DONE,
	input wire logic OFFSET_RESULT_VALID,
	input wire logic [2:0] OFFSET_RESULT_IDX,
	input wire logic [TRIM_W-1:0] OFFSET_RESULT,
	output abcc_pkg::abcc_cal_req_t CAL_REQ,
	output logic [2:0] CORE_POWER_ON,
	output logic [1:0] SLOT_A_CORE,
	output logic [1:0] SLOT_B_CORE,
	output logic SWAP_STROBE,
	output logic DATA_BLANK,
	output logic FOREGROUND_DONE,
	output logic [TRIM_W-1:0] SLOT_A_TIMING_TRIM,
	output logic [TRIM_W-1:0] SLOT_B_TIMING_TRIM,
	output logic [6*TRIM_W-1:0] BANK_TIMING_TRIM,
	output logic [6*TRIM_W-1:0] INPUT_OFFSET_TRIM
);
	localparam int NE = abcc_pkg::TRIM_ENTRIES;

	if (TRIM_W < 1 || TRIM_W > 16) begin : g_bad_w
		$error("Trim width must be 1 to 16 bits.");
	end

	abcc_pkg::abcc_ctrl_t ctrl_reg;
	abcc_pkg::abcc_state_t state_reg;
	abcc_pkg::abcc_state_t state_next;
	logic [31:0] delay_reg;
	logic [4:0] trim_sel_reg;
	logic [abcc_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [abcc_pkg::IRQ_W-1:0] irq_stat_next;
	logic [abcc_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [abcc_pkg::IRQ_W-1:0] irq_evt;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [1:0] swap_cnt_reg;
	logic fg_pend_reg;
	logic foreground_done_flag_reg;
	logic os_once_reg;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_s3_reg;
	logic [NE*TRIM_W-1:0] trim_flat;
	logic [TRIM_W-1:0] ent [NE];
	logic [6*TRIM_W-1:0] bank_next;

	// Bus decode.
	wire ahb_go = HSEL & HTRANS[1] & HREADY;
	wire [7:0] a_addr = HADDR[7:0];
	wire a_hi_zero = (HADDR[31:8] == 24'h00_0000);
	wire rd_go = ahb_go & ~HWRITE & a_hi_zero;
	wire wr_ctrl = wr_pend_reg & (wr_addr_reg == abcc_pkg::ADDR_CTRL);
	wire wr_delay = wr_pend_reg & (wr_addr_reg == abcc_pkg::ADDR_DELAY);
	wire wr_mask = wr_pend_reg & (wr_addr_reg == abcc_pkg::ADDR_IRQ_MASK);
	wire wr_sel = wr_pend_reg & (wr_addr_reg == abcc_pkg::ADDR_TRIM_SEL);
	wire wr_trim = wr_pend_reg & (wr_addr_reg == abcc_pkg::ADDR_TRIM_DATA);
	wire rd_irq = rd_go & (a_addr == abcc_pkg::ADDR_IRQ_STAT);

	// Trigger sources; the pin edge is taken from the second and third stages of the pin sync.
	wire pin_rise = pin_s2_reg & ~pin_s3_reg;
	wire sw_rise = wr_ctrl & HWDATA[2] & ~ctrl_reg.sw_trig;
	wire trig_evt = ctrl_reg.pin_sel ? pin_rise : sw_rise;
	// A write that turns background on is not a foreground trigger.
	wire bg_arm = wr_ctrl & HWDATA[0];

	// Core roles.
	wire [1:0] spare = abcc_pkg::CORE_SUM - SLOT_A_CORE - SLOT_B_CORE;
	wire [2:0] spare_hot = 3'b001 << spare;
	wire tgt_slot = swap_cnt_reg[1];
	wire [15:0] sleep_dly = delay_reg[15:0];
	wire [15:0] wake_dly = delay_reg[31:16];
	wire os_in_use = ctrl_reg.fg_os | ctrl_reg.bg_os;
	wire spare_awake = ctrl_reg.bg_en & (~ctrl_reg.low_power_bg_enable
		| state_reg == abcc_pkg::ST_WAKE | state_reg == abcc_pkg::ST_CAL
		| state_reg == abcc_pkg::ST_SWAP);
	wire [2:0] power_next = (3'b001 << SLOT_A_CORE) | (3'b001 << SLOT_B_CORE)
		| (spare_awake ? spare_hot : 3'b000);
	wire enter_fg = state_next == abcc_pkg::ST_FG
		&& state_reg != abcc_pkg::ST_FG;
	wire enter_cal = state_next == abcc_pkg::ST_CAL
		&& state_reg != abcc_pkg::ST_CAL;
	wire do_swap = state_reg == abcc_pkg::ST_SWAP;
	// The core released by a swap is the next one to calibrate.
	wire [1:0] next_spare = do_swap
		? (tgt_slot ? SLOT_B_CORE : SLOT_A_CORE) : spare;

	// Trim writes: calibration results win over software.
	wire sw_ofs = trim_sel_reg < abcc_pkg::IDX_OFS_END;
	wire sw_refused = wr_trim & sw_ofs & os_in_use;
	wire sw_trim_ok = wr_trim & ~sw_refused & (trim_sel_reg < 5'(NE));
	wire trim_we = OFFSET_RESULT_VALID | sw_trim_ok;
	wire [4:0] trim_waddr = OFFSET_RESULT_VALID
		? {2'b00, OFFSET_RESULT_IDX} : trim_sel_reg;
	wire [TRIM_W-1:0] trim_wdata = OFFSET_RESULT_VALID
		? OFFSET_RESULT : HWDATA[TRIM_W-1:0];

	abcc_trim_store #(
		.TRIM_W(TRIM_W),
		.ENTRIES(NE)
	) u_store (
		.clk(REF_CLK),
		.rst(RST),
		.we(trim_we),
		.waddr(trim_waddr),
		.wdata(trim_wdata),
		.trims(trim_flat)
	);

	for (genvar g = 0; g < NE; g++) begin : g_ent
		assign ent[g] = trim_flat[g*TRIM_W +: TRIM_W];
	end

	// Bank b uses entry 6+2b at 0 deg, 7+2b at -90 deg.
	for (genvar b = 0; b < 6; b++) begin : g_bank
		assign bank_next[b*TRIM_W +: TRIM_W] = ctrl_reg.single_ch
			? ent[abcc_pkg::IDX_BANK + 5'(2*b+1)]
			: ent[abcc_pkg::IDX_BANK + 5'(2*b)];
	end

	// Picks the inter-core trim for a slot and the core standing in it.
	function automatic logic [4:0] slot_trim(
		input logic slot,
		input logic [1:0] core,
		input logic single,
		input logic bg
	);
		logic is_c;
		is_c = core == abcc_pkg::CORE_C;
		if (!single) begin
			if (!slot) begin
				slot_trim = is_c ? abcc_pkg::IDX_DUAL_CA
					: abcc_pkg::IDX_DUAL_A;
			end else begin
				slot_trim = is_c ? abcc_pkg::IDX_DUAL_CB
					: abcc_pkg::IDX_DUAL_B;
			end
		end else if (!slot) begin
			slot_trim = is_c ? abcc_pkg::IDX_C_BG90
				: (bg ? abcc_pkg::IDX_A_BG90 : abcc_pkg::IDX_A_FG90);
		end else begin
			slot_trim = is_c ? abcc_pkg::IDX_C_BG0
				: (bg ? abcc_pkg::IDX_B_BG0 : abcc_pkg::IDX_B_FG0);
		end
	endfunction

	wire [4:0] idx_a = slot_trim(1'b0, SLOT_A_CORE, ctrl_reg.single_ch,
		ctrl_reg.bg_en);
	wire [4:0] idx_b = slot_trim(1'b1, SLOT_B_CORE, ctrl_reg.single_ch,
		ctrl_reg.bg_en);

	// Sequencer.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			abcc_pkg::ST_IDLE: begin
				if (fg_pend_reg
					|| (trig_evt && !ctrl_reg.bg_en && !bg_arm)) begin
					state_next = abcc_pkg::ST_FG;
				end else if (ctrl_reg.bg_en && ctrl_reg.fg_os
					&& !os_once_reg) begin
					state_next = abcc_pkg::ST_FG;
				end else if (ctrl_reg.bg_en) begin
					state_next = ctrl_reg.low_power_bg_enable ? abcc_pkg::ST_SLEEP
						: abcc_pkg::ST_CAL;
				end
			end
			abcc_pkg::ST_FG: begin
				if (CORE_CAL_DONE) begin
					state_next = abcc_pkg::ST_IDLE;
				end
			end
			abcc_pkg::ST_SLEEP: begin
				if (!ctrl_reg.bg_en) begin
					state_next = abcc_pkg::ST_IDLE;
				end else if (ctrl_reg.low_power_trigger_select ? trig_evt
					: cnt_reg >= sleep_dly) begin
					state_next = abcc_pkg::ST_WAKE;
				end
			end
			abcc_pkg::ST_WAKE: begin
				if (!ctrl_reg.bg_en) begin
					state_next = abcc_pkg::ST_IDLE;
				end else if (cnt_reg >= wake_dly) begin
					state_next = abcc_pkg::ST_CAL;
				end
			end
			abcc_pkg::ST_CAL: begin
				if (CORE_CAL_DONE) begin
					state_next = abcc_pkg::ST_SWAP;
				end
			end
			abcc_pkg::ST_SWAP: begin
				if (!ctrl_reg.bg_en) begin
					state_next = abcc_pkg::ST_IDLE;
				end else begin
					state_next = ctrl_reg.low_power_bg_enable ? abcc_pkg::ST_SLEEP
						: abcc_pkg::ST_CAL;
				end
			end
			default: begin
				state_next = abcc_pkg::ST_IDLE;
			end
		endcase
	end

	assign cnt_next = (state_next != state_reg) ? 16'h0000
		: (cnt_reg == 16'hFFFF ? cnt_reg : cnt_reg + 16'h0001);

	always_comb begin
		irq_evt = '0;
		irq_evt[abcc_pkg::IRQ_FOREGROUND_DONE_FLAG] = state_reg == abcc_pkg::ST_FG
			&& CORE_CAL_DONE;
		irq_evt[abcc_pkg::IRQ_SWAP] = do_swap;
		irq_evt[abcc_pkg::IRQ_PASS] = state_reg == abcc_pkg::ST_CAL
			&& CORE_CAL_DONE;
		irq_evt[abcc_pkg::IRQ_REFUSED] = sw_refused;
	end

	// A new event wins over a clearing read in the same cycle.
	assign irq_stat_next = (irq_stat_reg & ~{abcc_pkg::IRQ_W{rd_irq}})
		| irq_evt;

	wire [31:0] status_w = {18'h0_0000, foreground_done_flag_reg, os_once_reg,
		state_reg, spare, SLOT_B_CORE, SLOT_A_CORE, CORE_POWER_ON};
	wire [31:0] trim_rd = (trim_sel_reg < 5'(NE))
		? 32'(ent[trim_sel_reg]) : 32'h0000_0000;
	wire [31:0] rd_mux =
		a_addr == abcc_pkg::ADDR_CTRL ? 32'(ctrl_reg) :
		a_addr == abcc_pkg::ADDR_DELAY ? delay_reg :
		a_addr == abcc_pkg::ADDR_STATUS ? status_w :
		a_addr == abcc_pkg::ADDR_IRQ_STAT ? 32'(irq_stat_reg) :
		a_addr == abcc_pkg::ADDR_IRQ_MASK ? 32'(irq_mask_reg) :
		a_addr == abcc_pkg::ADDR_TRIM_SEL ? 32'(trim_sel_reg) :
		a_addr == abcc_pkg::ADDR_TRIM_DATA ? trim_rd : 32'h0000_0000;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			HRDATA <= 32'h0000_0000;
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
			ctrl_reg <= abcc_pkg::CTRL_RST;
			delay_reg <= abcc_pkg::DELAY_RST;
			irq_mask_reg <= '0;
			trim_sel_reg <= 5'h00;
		end else begin
			wr_pend_reg <= ahb_go & HWRITE & a_hi_zero;
			wr_addr_reg <= a_addr;
			HRDATA <= rd_go ? rd_mux : 32'h0000_0000;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
			if (wr_ctrl) ctrl_reg <= HWDATA[7:0];
			if (wr_delay) delay_reg <= HWDATA;
			if (wr_mask) irq_mask_reg <= HWDATA[abcc_pkg::IRQ_W-1:0];
			if (wr_sel) trim_sel_reg <= HWDATA[4:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			state_reg <= abcc_pkg::ST_IDLE;
			cnt_reg <= 16'h0000;
			swap_cnt_reg <= 2'h0;
			fg_pend_reg <= 1'b1;
			foreground_done_flag_reg <= 1'b0;
			os_once_reg <= 1'b0;
			SLOT_A_CORE <= abcc_pkg::CORE_A;
			SLOT_B_CORE <= abcc_pkg::CORE_B;
			SWAP_STROBE <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			SWAP_STROBE <= do_swap;
			if (enter_fg) fg_pend_reg <= 1'b0;
			if (enter_fg) foreground_done_flag_reg <= 1'b0;
			if (irq_evt[abcc_pkg::IRQ_FOREGROUND_DONE_FLAG]) foreground_done_flag_reg <= 1'b1;
			if (enter_fg && ctrl_reg.bg_en) os_once_reg <= 1'b1;
			if (!ctrl_reg.bg_en) os_once_reg <= 1'b0;
			if (do_swap) begin
				swap_cnt_reg <= swap_cnt_reg + 2'h1;
				if (!tgt_slot) SLOT_A_CORE <= spare;
				if (tgt_slot) SLOT_B_CORE <= spare;
			end
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_s3_reg <= 1'b0;
			irq_stat_reg <= '0;
			IRQ <= 1'b0;
			CAL_REQ <= '0;
			CORE_POWER_ON <= 3'b000;
			DATA_BLANK <= 1'b0;
			FOREGROUND_DONE <= 1'b0;
			SLOT_A_TIMING_TRIM <= '0;
			SLOT_B_TIMING_TRIM <= '0;
			BANK_TIMING_TRIM <= '0;
			INPUT_OFFSET_TRIM <= '0;
		end else begin
			pin_s1_reg <= CAL_TRIGGER_PIN;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			irq_stat_reg <= irq_stat_next;
			IRQ <= |(irq_stat_next & irq_mask_reg);
			CAL_REQ.start <= enter_fg | enter_cal;
			CAL_REQ.core <= enter_fg ? abcc_pkg::CORE_ALL : next_spare;
			CAL_REQ.offset <= enter_fg ? ctrl_reg.fg_os
				: ctrl_reg.bg_os;
			CORE_POWER_ON <= power_next;
			DATA_BLANK <= state_next == abcc_pkg::ST_FG;
			FOREGROUND_DONE <= foreground_done_flag_reg;
			SLOT_A_TIMING_TRIM <= ent[idx_a];
			SLOT_B_TIMING_TRIM <= ent[idx_b];
			BANK_TIMING_TRIM <= bank_next;
			INPUT_OFFSET_TRIM <= trim_flat[6*TRIM_W-1:0];
		end
	end

	a_bg_spare_cal: assert property (@(posedge REF_CLK) disable iff (RST)
		CAL_REQ.start && state_reg == abcc_pkg::ST_CAL
		|-> CAL_REQ.core == spare)
		else $error("Background pass did not target the spare core.");
	a_lp_spare_off: assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == abcc_pkg::ST_SLEEP && $past(state_reg)
		== abcc_pkg::ST_SLEEP |-> (CORE_POWER_ON & spare_hot) == 3'b000)
		else $error("Sleeping spare core is powered.");
	a_sleep_delay_met: assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == abcc_pkg::ST_SLEEP && state_next
		== abcc_pkg::ST_WAKE && !ctrl_reg.low_power_trigger_select
		|-> cnt_reg >= sleep_dly)
		else $error("Spare woke before the sleep delay.");
	a_wake_delay_met: assert property (@(posedge REF_CLK) disable iff (RST)
		$rose(state_reg == abcc_pkg::ST_CAL)
		&& $past(state_reg) == abcc_pkg::ST_WAKE
		|-> $past(cnt_reg) >= $past(wake_dly))
		else $error("Calibration began before wake settling.");
	a_user_swap_only: assert property (@(posedge REF_CLK) disable iff (RST)
		state_reg == abcc_pkg::ST_SLEEP && ctrl_reg.low_power_trigger_select && !trig_evt
		&& ctrl_reg.bg_en |=> state_reg == abcc_pkg::ST_SLEEP)
		else $error("Spare woke without a user trigger.");
	a_fg_offset_req: assert property (@(posedge REF_CLK) disable iff (RST)
		CAL_REQ.start && CAL_REQ.core == abcc_pkg::CORE_ALL
		|-> CAL_REQ.offset == $past(ctrl_reg.fg_os))
		else $error("Foreground offset request mismatch.");
	a_bg_offset_req: assert property (@(posedge REF_CLK) disable iff (RST)
		CAL_REQ.start && CAL_REQ.core != abcc_pkg::CORE_ALL
		|-> CAL_REQ.offset == $past(ctrl_reg.bg_os))
		else $error("Background offset request mismatch.");
	a_offset_guard: assert property (@(posedge REF_CLK) disable iff (RST)
		trim_we && trim_waddr < abcc_pkg::IDX_OFS_END
		|-> OFFSET_RESULT_VALID || !os_in_use)
		else $error("Software wrote an offset trim during offset cal.");
	a_swap_one_slot: assert property (@(posedge REF_CLK) disable iff (RST)
		SWAP_STROBE |-> (SLOT_A_CORE != $past(SLOT_A_CORE))
		!= (SLOT_B_CORE != $past(SLOT_B_CORE)))
		else $error("Swap did not move exactly one slot.");
	a_pulse_single: assert property (@(posedge REF_CLK) disable iff (RST)
		CAL_REQ.start |=> !CAL_REQ.start)
		else $error("Calibration start held over two cycles.");
endmodule

// file: tb/abcc_tb.sv
/*
 * Self-checking testbench of the background calibration controller.
 * Assumes the bench acts as AHB-Lite master and as calibration engine.
 */
`timescale 1ns/10ps
module tb;
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = 3'h2;
	logic CAL_TRIGGER_PIN = 1'b0;
	logic CORE_CAL_DONE = 1'b0;
	logic OFFSET_RESULT_VALID = 1'b0;
	logic [2:0] OFFSET_RESULT_IDX = 3'h0;
	logic [15:0] OFFSET_RESULT = 16'h0000;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic IRQ;
	abcc_pkg::abcc_cal_req_t CAL_REQ;
	logic [2:0] CORE_POWER_ON;
	logic [1:0] SLOT_A_CORE;
	logic [1:0] SLOT_B_CORE;
	logic SWAP_STROBE;
	logic DATA_BLANK;
	logic FOREGROUND_DONE;
	logic [15:0] SLOT_A_TIMING_TRIM;
	logic [15:0] SLOT_B_TIMING_TRIM;
	logic [95:0] BANK_TIMING_TRIM;
	logic [95:0] INPUT_OFFSET_TRIM;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	int k;
	logic [31:0] rd;

	abcc_ctrl #(.TRIM_W(16)) u_dut (.REF_CLK(REF_CLK), .RST(RST),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ),
		.CAL_TRIGGER_PIN(CAL_TRIGGER_PIN), .CORE_CAL_DONE(CORE_CAL_DONE),
		.OFFSET_RESULT_VALID(OFFSET_RESULT_VALID),
		.OFFSET_RESULT_IDX(OFFSET_RESULT_IDX), .OFFSET_RESULT(OFFSET_RESULT),
		.CAL_REQ(CAL_REQ), .CORE_POWER_ON(CORE_POWER_ON),
		.SLOT_A_CORE(SLOT_A_CORE), .SLOT_B_CORE(SLOT_B_CORE),
		.SWAP_STROBE(SWAP_STROBE), .DATA_BLANK(DATA_BLANK),
		.FOREGROUND_DONE(FOREGROUND_DONE),
		.SLOT_A_TIMING_TRIM(SLOT_A_TIMING_TRIM),
		.SLOT_B_TIMING_TRIM(SLOT_B_TIMING_TRIM),
		.BANK_TIMING_TRIM(BANK_TIMING_TRIM),
		.INPUT_OFFSET_TRIM(INPUT_OFFSET_TRIM));

	always #10 REF_CLK = ~REF_CLK;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("BAD %0t timeout", $time);
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h00_0000, a};
		HWRITE <= w;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string what);
		ahb(1'b0, a, 32'h0000_0000);
		chk(rd, e, what);
	endtask

	task automatic tw(input logic [4:0] i, input logic [15:0] d);
		ahb(1'b1, abcc_pkg::ADDR_TRIM_SEL, {27'h000_0000, i});
		ahb(1'b1, abcc_pkg::ADDR_TRIM_DATA, {16'h0000, d});
	endtask

	task automatic wait_start(input int lim, output int n);
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (CAL_REQ.start !== 1'b1 && n < lim);
	endtask

	task automatic wait_swap;
		int n;
		n = 0;
		do begin
			@(posedge REF_CLK);
			n++;
		end while (SWAP_STROBE !== 1'b1 && n < 300);
		chk(SWAP_STROBE, 1'b1, "no swap");
	endtask

	task automatic done_pulse;
		CORE_CAL_DONE <= 1'b1;
		@(posedge REF_CLK);
		CORE_CAL_DONE <= 1'b0;
	endtask

	task automatic t_fg;
		int n;
		wait_start(300, n);
		chk(CAL_REQ.core, abcc_pkg::CORE_ALL, "fg core");
		tick(1);
		chk(DATA_BLANK, 1'b1, "fg blank");
		rdc(abcc_pkg::ADDR_CTRL, {24'h00_0000, abcc_pkg::CTRL_RST}, "ctrl");
		rdc(abcc_pkg::ADDR_DELAY, abcc_pkg::DELAY_RST, "delay");
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rdc(8'h40, 32'h0000_0000, "unmapped");
		chk(HRESP, 1'b0, "resp");
		ahb(1'b1, abcc_pkg::ADDR_IRQ_MASK, 32'h0000_000F);
		done_pulse();
		tick(3);
		chk(FOREGROUND_DONE, 1'b1, "foreground_done_flag");
		chk(DATA_BLANK, 1'b0, "fg unblank");
		chk(IRQ, 1'b1, "irq up");
		rdc(abcc_pkg::ADDR_IRQ_STAT, 32'h0000_0001, "irq stat");
		tick(2);
		chk(IRQ, 1'b0, "irq cleared");
		$display("test fg finished");
	endtask

	task automatic t_trim;
		tw(5'h10, 16'h5A5A);
		tw(5'h11, 16'h0F0F);
		tw(abcc_pkg::IDX_DUAL_A, 16'h1111);
		tw(abcc_pkg::IDX_DUAL_B, 16'h2222);
		tw(abcc_pkg::IDX_DUAL_CA, 16'h3333);
		tw(abcc_pkg::IDX_DUAL_CB, 16'h4444);
		tw(abcc_pkg::IDX_A_FG90, 16'h6666);
		tw(abcc_pkg::IDX_B_FG0, 16'h7777);
		tick(2);
		chk(BANK_TIMING_TRIM[80+:16], 16'h5A5A, "bank dual");
		chk(SLOT_A_TIMING_TRIM, 16'h1111, "dual a");
		chk(SLOT_B_TIMING_TRIM, 16'h2222, "dual b");
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0080);
		tick(2);
		chk(BANK_TIMING_TRIM[80+:16], 16'h0F0F, "bank single");
		chk(SLOT_A_TIMING_TRIM, 16'h6666, "single a");
		chk(SLOT_B_TIMING_TRIM, 16'h7777, "single b");
		ahb(1'b1, abcc_pkg::ADDR_TRIM_SEL, 32'h0000_0011);
		rdc(abcc_pkg::ADDR_TRIM_DATA, 32'h0000_0F0F, "trim read");
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0000);
		$display("test trim finished");
	endtask

	task automatic t_bg;
		logic [1:0] sp[4] = '{2'h2, 2'h0, 2'h2, 2'h1};
		logic [1:0] sa[4] = '{2'h2, 2'h0, 2'h0, 2'h0};
		logic [1:0] sb[4] = '{2'h1, 2'h1, 2'h2, 2'h1};
		logic [15:0] ta[4] = '{16'h3333, 16'h1111, 16'h1111, 16'h1111};
		logic [15:0] tb2[4] = '{16'h2222, 16'h2222, 16'h4444, 16'h2222};
		int n;
		ahb(1'b1, abcc_pkg::ADDR_DELAY, 32'h0004_0004);
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0045);
		wait_start(300, n);
		for (int i = 0; i < 4; i++) begin
			chk(CAL_REQ.core, sp[i], "spare core");
			chk(CAL_REQ.offset, 1'b1, "bg offset");
			done_pulse();
			wait_swap();
			chk(SLOT_A_CORE, sa[i], "slot a");
			chk(SLOT_B_CORE, sb[i], "slot b");
			chk(CAL_REQ.start, 1'b1, "next pass");
			chk(DATA_BLANK, 1'b0, "bg blank");
			tick(2);
			chk(SLOT_A_TIMING_TRIM, ta[i], "trim a");
			chk(SLOT_B_TIMING_TRIM, tb2[i], "trim b");
		end
		tw(5'h00, 16'h1234);
		ahb(1'b0, abcc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
		chk(rd[abcc_pkg::IRQ_REFUSED], 1'b1, "refused irq");
		chk(INPUT_OFFSET_TRIM[15:0], 16'h0000, "refused trim");
		OFFSET_RESULT_IDX <= 3'h3;
		OFFSET_RESULT <= 16'h00AB;
		OFFSET_RESULT_VALID <= 1'b1;
		tick(1);
		OFFSET_RESULT_VALID <= 1'b0;
		tick(2);
		chk(INPUT_OFFSET_TRIM[48+:16], 16'h00AB, "ofs entry");
		chk(INPUT_OFFSET_TRIM[32+:16], 16'h0000, "ofs other");
		ahb(1'b1, abcc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0000);
		done_pulse();
		tick(2);
		chk(IRQ, 1'b0, "irq masked");
		$display("test bg finished");
	endtask

	task automatic t_os;
		int n;
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0025);
		wait_start(300, n);
		chk(CAL_REQ.core, abcc_pkg::CORE_ALL, "one-shot core");
		chk(CAL_REQ.offset, 1'b1, "one-shot offset");
		tick(1);
		chk(DATA_BLANK, 1'b1, "one-shot blank");
		done_pulse();
		wait_start(300, n);
		chk(CAL_REQ.offset, 1'b0, "no tracking");
		ahb(1'b0, abcc_pkg::ADDR_STATUS, 32'h0000_0000);
		chk(rd[12], 1'b1, "one-shot done");
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0000);
		done_pulse();
		$display("test one-shot finished");
	endtask

	task automatic t_lp;
		int n;
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_000D);
		wait_start(300, n);
		chk(CORE_POWER_ON[CAL_REQ.core], 1'b1, "spare awake");
		done_pulse();
		wait_swap();
		tick(3);
		chk($countones(CORE_POWER_ON), 2, "spare asleep");
		wait_start(300, n);
		chk(n + 3 >= 8, 1'b1, "lp too soon");
		chk(n + 3 <= 16, 1'b1, "lp too late");
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_001D);
		done_pulse();
		wait_swap();
		wait_start(60, n);
		chk(CAL_REQ.start, 1'b0, "auto swap");
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0019);
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_001D);
		wait_start(100, n);
		chk(CAL_REQ.start, 1'b1, "user trigger");
		done_pulse();
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0000);
		ahb(1'b1, abcc_pkg::ADDR_CTRL, 32'h0000_0002);
		CAL_TRIGGER_PIN <= 1'b1;
		wait_start(20, n);
		chk(CAL_REQ.core, abcc_pkg::CORE_ALL, "pin trigger");
		done_pulse();
		CAL_TRIGGER_PIN <= 1'b0;
		$display("test low power finished");
	endtask

	initial begin
		repeat (16) @(posedge REF_CLK);
		RST <= 1'b0;
		t_fg();
		t_trim();
		t_bg();
		t_os();
		t_lp();
		wrap_up();
	end
endmodule
